//--- rtl/scm_consts.svh
// Register offsets, field positions, reset values and timing counts of the clock controller.
// Included by the controller and the testbench; holds definitions only.
`ifndef SCM_CONSTS_SVH
`define SCM_CONSTS_SVH
`define SCM_ADR_SCC 4'h0
`define SCM_ADR_FOC 4'h4
`define SCM_ADR_STAT 4'h8
`define SCM_SCC_RESET 8'h00
`define SCM_FOC_EN_RESET 1'b1
`define SCM_SEL_HI 7
`define SCM_SEL_LO 5
`define SCM_KEEP_FAST_BIT 1
`define SCM_KEEP_SLOW_BIT 0
`define SCM_FOC_STABLE_BIT 1
`define SCM_FOC_EN_BIT 0
`define SCM_SEL_SUB 3'h7
`define SCM_SYS_KHZ 25000
`define SCM_FAST_OSC_KHZ 8000
`define SCM_SLOW_OSC_KHZ 32
`define SCM_SYS_PERIOD_NS 40
`define SCM_SETTLE_NS 16000
`define SCM_SETTLE_CYC ((`SCM_SETTLE_NS + `SCM_SYS_PERIOD_NS - 1) / `SCM_SYS_PERIOD_NS)
`endif

//--- rtl/scm_pkg.sv
// Types of the system clock and mode controller.
// Assumes nothing of its surroundings.
package scm_pkg;
  typedef enum logic [2:0] {SCM_FAST, SCM_SLOW, SCM_IDLE0, SCM_IDLE1, SCM_IDLE2,
    SCM_SLEEP} scm_mode_t;
  typedef struct packed {
    logic [15:0] acc;
    logic tick;
  } scm_tick_state_t;
  typedef struct packed {
    logic halted;
    logic [2:0] sel;
    logic keep_fast;
    logic keep_slow;
    logic foc_en;
    logic stable;
    logic [8:0] settle;
    logic [2:0] act_sel;
    logic [5:0] div;
    logic ack;
    logic [7:0] rdata;
    scm_mode_t op_mode;
    logic fast_tick;
    logic sub_tick;
    logic slow_rc_osc_tick;
    logic sys_tick;
    logic fast_run;
    logic slow_run;
    logic cpu_run;
  } scm_state_t;
endpackage

//--- rtl/scm_tick_gen.sv
// Model of one internal RC oscillator as a stream of one-cycle ticks on sys_clk.
// Assumes the nominal rate is below the sys_clk rate; a fractional accumulator spaces ticks.
`timescale 1ns/1ps
module scm_tick_gen import scm_pkg::*; #(
  parameter int INC = 1,
  parameter int MOD = 2
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic run,
  output logic tick
);
  scm_tick_state_t st;
  scm_tick_state_t next_st;
  logic [15:0] sum;

  // A stopped oscillator restarts from zero phase so no early tick appears.
  always_comb begin
    next_st = st;
    sum = st.acc + 16'(INC);
    next_st.tick = 1'b0;
    if (!run) begin
      next_st.acc = 16'h0000;
    end else if (sum >= 16'(MOD)) begin
      next_st.acc = sum - 16'(MOD);
      next_st.tick = 1'b1;
    end else begin
      next_st.acc = sum;
    end
  end

  // State register.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule

//--- rtl/scm_clock_ctrl.sv
// System clock source selection and operating-mode control with its Wishbone registers.
// Assumes halt and wake pulses and the watchdog enable come from logic on sys_clk.
`timescale 1ns/1ps
`include "scm_consts.svh"
module scm_clock_ctrl import scm_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic halt,
  input wire logic wake,
  input wire logic wdt_enable,
  output logic cpu_run,
  output logic fast_osc_run,
  output logic slow_osc_run,
  output logic fast_clock,
  output logic sub_clock,
  output logic slow_osc_clock,
  output logic system_clock,
  output logic [2:0] op_mode
);
  scm_state_t st;
  scm_state_t next_st;
  logic fast_raw;
  logic slow_rc_osc_raw;
  logic req;
  logic wr;
  logic fast_on;
  logic sub_on;
  logic slow_rc_osc_on;
  logic sys_gate;
  logic src_tick;
  logic div_hit;
  logic new_ready;
  logic cur_ready;

  // Mode decode, shared by the status read and the mode output.
  function automatic scm_mode_t mode_of(input logic halted, input logic [2:0] sel,
                                        input logic kf, input logic ks);
    if (!halted) begin
      mode_of = (sel == `SCM_SEL_SUB) ? SCM_SLOW : SCM_FAST;
    end else begin
      case ({kf, ks})
        2'b01: mode_of = SCM_IDLE0;
        2'b11: mode_of = SCM_IDLE1;
        2'b10: mode_of = SCM_IDLE2;
        default: mode_of = SCM_SLEEP;
      endcase
    end
  endfunction

  // Terminal count of the divider: ratio minus one for codes 0..6.
  function automatic logic [5:0] div_last(input logic [2:0] sel);
    logic [6:0] one;
    one = 7'h01 << sel;
    div_last = 6'(one - 7'h01);
  endfunction

  // The two RC oscillators, modelled as tick streams on sys_clk.
  scm_tick_gen #(.INC(`SCM_FAST_OSC_KHZ), .MOD(`SCM_SYS_KHZ)) u_fast_osc (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(fast_on),
    .tick(fast_raw)
  );
  scm_tick_gen #(.INC(`SCM_SLOW_OSC_KHZ), .MOD(`SCM_SYS_KHZ)) u_slow_osc (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(slow_rc_osc_on),
    .tick(slow_rc_osc_raw)
  );

  // Oscillator gating by mode; while running the fast one stays up while it is or will be the source.
  always_comb begin
    if (!st.halted) begin
      fast_on = st.foc_en || st.act_sel != `SCM_SEL_SUB || st.sel != `SCM_SEL_SUB;
      sub_on = 1'b1;
      slow_rc_osc_on = 1'b1;
    end else begin
      fast_on = st.keep_fast;
      sub_on = st.keep_slow;
      slow_rc_osc_on = st.keep_slow || st.keep_fast || wdt_enable;
    end
    // While halted the system clock lives only if its source was kept.
    sys_gate = !st.halted || ((st.act_sel == `SCM_SEL_SUB) ? st.keep_slow : st.keep_fast);
  end

  // Source tick and divider terminal count.
  always_comb begin
    div_hit = (st.div == div_last(st.act_sel));
    if (st.act_sel == `SCM_SEL_SUB) begin
      src_tick = slow_rc_osc_raw && sub_on;
      cur_ready = sub_on;
    end else begin
      src_tick = fast_raw && st.stable && div_hit;
      cur_ready = st.stable;
    end
    new_ready = (st.sel == `SCM_SEL_SUB) ? sub_on : st.stable;
  end

  assign req = wb_cyc_i && wb_stb_i;
  assign wr = req && wb_we_i && st.ack && wb_sel_i[0];

  // Next-state logic of the whole controller.
  always_comb begin
    next_st = st;
    // Classic bus: ack one cycle after the request, dropped the cycle after.
    next_st.ack = req && !st.ack;
    case (wb_adr_i)
      `SCM_ADR_SCC: next_st.rdata = {st.sel, 3'h0, st.keep_fast, st.keep_slow};
      `SCM_ADR_FOC: next_st.rdata = {6'h00, st.stable, st.foc_en};
      `SCM_ADR_STAT: next_st.rdata = {5'h00, 3'(mode_of(st.halted, st.act_sel,
                                                      st.keep_fast, st.keep_slow))};
      default: next_st.rdata = 8'h00;
    endcase
    // Register writes take effect on the edge where ack is high.
    if (wr && wb_adr_i == `SCM_ADR_SCC) begin
      next_st.sel = wb_dat_i[`SCM_SEL_HI:`SCM_SEL_LO];
      next_st.keep_fast = wb_dat_i[`SCM_KEEP_FAST_BIT];
      next_st.keep_slow = wb_dat_i[`SCM_KEEP_SLOW_BIT];
    end
    if (wr && wb_adr_i == `SCM_ADR_FOC) begin
      next_st.foc_en = wb_dat_i[`SCM_FOC_EN_BIT];
    end
    // Halt enters the low-power modes; wake returns to running and wins a tie.
    if (wake) begin
      next_st.halted = 1'b0;
    end else if (halt) begin
      next_st.halted = 1'b1;
    end
    // Settle timer: stopped oscillator or a fresh enable write restarts it.
    if (!fast_on || (wr && wb_adr_i == `SCM_ADR_FOC && wb_dat_i[`SCM_FOC_EN_BIT])) begin
      next_st.stable = 1'b0;
      next_st.settle = 9'h000;
    end else if (st.settle == 9'(`SCM_SETTLE_CYC - 1)) begin
      next_st.stable = 1'b1;
    end else begin
      next_st.settle = st.settle + 9'h001;
    end
    // Divider counts fast ticks; it restarts on every source change.
    if (fast_raw && st.act_sel != `SCM_SEL_SUB) begin
      next_st.div = div_hit ? 6'h00 : st.div + 6'h01;
    end
    // Switch at an output boundary of the old source, or at once if the old one is not ready, once the new one runs.
    if (st.sel != st.act_sel && new_ready && (src_tick || !cur_ready)) begin
      next_st.act_sel = st.sel;
      next_st.div = 6'h00;
    end
    // Registered outputs, all derived from the same present state.
    next_st.sys_tick = src_tick && sys_gate;
    // A tick already in flight must not escape once the oscillator is being stopped.
    next_st.fast_tick = fast_raw && st.stable && fast_on;
    next_st.sub_tick = slow_rc_osc_raw && sub_on;
    next_st.slow_rc_osc_tick = slow_rc_osc_raw;
    next_st.fast_run = fast_on;
    next_st.slow_run = slow_rc_osc_on;
    next_st.cpu_run = !st.halted;
    next_st.op_mode = mode_of(st.halted, st.act_sel, st.keep_fast, st.keep_slow);
  end

  // State register; power-on values of both control registers.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= '0;
      st.sel <= 3'(`SCM_SCC_RESET >> `SCM_SEL_LO);
      st.act_sel <= 3'(`SCM_SCC_RESET >> `SCM_SEL_LO);
      st.foc_en <= `SCM_FOC_EN_RESET;
      st.cpu_run <= 1'b1;
      st.fast_run <= 1'b1;
      st.slow_run <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign wb_ack_o = st.ack;
  assign wb_dat_o = {24'h000000, st.rdata};
  assign cpu_run = st.cpu_run;
  assign fast_osc_run = st.fast_run;
  assign slow_osc_run = st.slow_run;
  assign fast_clock = st.fast_tick;
  assign sub_clock = st.sub_tick;
  assign slow_osc_clock = st.slow_rc_osc_tick;
  assign system_clock = st.sys_tick;
  assign op_mode = 3'(st.op_mode);

  // Checks on the controller's own outputs and state.
  property p_rsv_zero;
    @(posedge sys_clk) disable iff (rst)
      (req && !wb_we_i && wb_adr_i == `SCM_ADR_SCC && !st.ack) |=> (wb_dat_o[4:2] == 3'h0);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("Reserved bits read non-zero.");

  property p_stable_clear;
    @(posedge sys_clk) disable iff (rst)
      (wr && wb_adr_i == `SCM_ADR_FOC && wb_dat_i[0]) |=> !st.stable ##1 !st.stable;
  endproperty
  a_stable_clear: assert property (p_stable_clear) else $error("Stable flag not cleared.");

  property p_sleep_off;
    @(posedge sys_clk) disable iff (rst)
      (op_mode == 3'(SCM_SLEEP)) |-> (!system_clock && !fast_clock && !sub_clock && !cpu_run);
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("Clock running in sleep.");

  property p_sleep_slow_rc_osc;
    @(posedge sys_clk) disable iff (rst)
      (op_mode == 3'(SCM_SLEEP)) |-> (slow_osc_run == $past(wdt_enable));
  endproperty
  a_sleep_slow_rc_osc: assert property (p_sleep_slow_rc_osc) else $error("Slow oscillator wrong in sleep.");

  property p_idle0;
    @(posedge sys_clk) disable iff (rst)
      (op_mode == 3'(SCM_IDLE0)) |-> (!fast_osc_run && slow_osc_run && !fast_clock);
  endproperty
  a_idle0: assert property (p_idle0) else $error("Idle0 oscillator state wrong.");

  property p_idle2;
    @(posedge sys_clk) disable iff (rst)
      (op_mode == 3'(SCM_IDLE2)) |-> (fast_osc_run && !sub_clock);
  endproperty
  a_idle2: assert property (p_idle2) else $error("Idle2 oscillator state wrong.");

  property p_fast_mode;
    @(posedge sys_clk) disable iff (rst)
      (op_mode == 3'(SCM_FAST)) |-> (fast_osc_run && slow_osc_run && cpu_run);
  endproperty
  a_fast_mode: assert property (p_fast_mode) else $error("Fast mode clocks not on.");

  property p_slow_src;
    @(posedge sys_clk) disable iff (rst)
      (op_mode == 3'(SCM_SLOW) && system_clock) |-> slow_osc_clock;
  endproperty
  a_slow_src: assert property (p_slow_src) else $error("Slow mode tick not from sub clock.");

  property p_reset_foc;
    @(posedge sys_clk) $fell(rst) |-> (st.foc_en && !st.stable);
  endproperty
  a_reset_foc: assert property (p_reset_foc) else $error("Fast osc control reset wrong.");

  // Outputs and state held against each other; the outputs are registered from one present state.
  property p_idle1;
    @(posedge sys_clk) disable iff (rst)
      (op_mode == 3'(SCM_IDLE1)) |-> (fast_osc_run && slow_osc_run && !cpu_run);
  endproperty
  a_idle1: assert property (p_idle1) else $error("Idle1 oscillator state wrong.");

  property p_idle0_sys;
    @(posedge sys_clk) disable iff (rst)
      (op_mode == 3'(SCM_IDLE0) && system_clock) |-> sub_clock;
  endproperty
  a_idle0_sys: assert property (p_idle0_sys) else $error("Idle0 tick not from sub.");

  property p_idle2_sys;
    @(posedge sys_clk) disable iff (rst)
      (op_mode == 3'(SCM_IDLE2) && system_clock) |-> fast_clock;
  endproperty
  a_idle2_sys: assert property (p_idle2_sys) else $error("Idle2 tick not from fast.");

  property p_slow_fast_en;
    @(posedge sys_clk) disable iff (rst)
      (op_mode == 3'(SCM_SLOW) && $past(st.sel) == `SCM_SEL_SUB) |->
        (fast_osc_run == $past(st.foc_en));
  endproperty
  a_slow_fast_en: assert property (p_slow_fast_en) else $error("Fast osc wrong in slow.");

  property p_switch_ready;
    @(posedge sys_clk) disable iff (rst)
      (st.act_sel != $past(st.act_sel) && st.act_sel != `SCM_SEL_SUB) |-> $past(st.stable);
  endproperty
  a_switch_ready: assert property (p_switch_ready) else $error("Switched before stable.");

  property p_cpu_mode;
    @(posedge sys_clk) disable iff (rst)
      cpu_run == (op_mode == 3'(SCM_FAST) || op_mode == 3'(SCM_SLOW));
  endproperty
  a_cpu_mode: assert property (p_cpu_mode) else $error("Run flag and mode disagree.");

  c_idle1: cover property (@(posedge sys_clk) disable iff (rst) op_mode == 3'(SCM_IDLE1));
  c_slow: cover property (@(posedge sys_clk) disable iff (rst) op_mode == 3'(SCM_SLOW));
  c_sleep: cover property (@(posedge sys_clk) disable iff (rst) op_mode == 3'(SCM_SLEEP));
  c_idle2: cover property (@(posedge sys_clk) disable iff (rst) op_mode == 3'(SCM_IDLE2));
endmodule

//--- tb/testbench.sv
// Self-checking bench for the system clock and mode controller.
// Assumes the controller answers Wishbone on sys_clk and models its oscillators as ticks.
`timescale 1ns/1ps
`include "scm_consts.svh"
module testbench import scm_pkg::*; ;
  // The scenarios need about 46000 cycles; the ceiling leaves a margin.
  localparam int LIMIT = 60000;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic halt = 1'b0;
  logic wake = 1'b0;
  logic wdt_enable = 1'b0;
  logic wb_ack_o, cpu_run, fast_osc_run, slow_osc_run;
  logic fast_clock, sub_clock, slow_osc_clock, system_clock;
  logic [31:0] wb_dat_o;
  logic [2:0] op_mode;
  logic [31:0] rd;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  int n_fast = 0, n_sub = 0, n_sys = 0, n_slow = 0;

  scm_clock_ctrl scm_clock_ctrl_i (.sys_clk(sys_clk), .rst(rst), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .halt(halt),
    .wake(wake), .wdt_enable(wdt_enable), .cpu_run(cpu_run), .fast_osc_run(fast_osc_run),
    .slow_osc_run(slow_osc_run), .fast_clock(fast_clock), .sub_clock(sub_clock),
    .slow_osc_clock(slow_osc_clock), .system_clock(system_clock), .op_mode(op_mode));

  // The clock toggles every half period of 40 ns.
  always #20 sys_clk = ~sys_clk;

  // Tick counters give rates; the cycle ceiling cuts a hang short.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    n_fast <= n_fast + int'(fast_clock === 1'b1);
    n_sub <= n_sub + int'(sub_clock === 1'b1);
    n_sys <= n_sys + int'(system_clock === 1'b1);
    n_slow <= n_slow + int'(slow_osc_clock === 1'b1);
    if (cycles == LIMIT) begin
      fails++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // One classic cycle; the request is held until ack is sampled high.
  task automatic wb_cycle(input logic [3:0] a, input logic w, input logic [31:0] d,
                          output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    if (n >= 50) check(32'(wb_ack_o), 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb_cycle(a, 1'b1, {24'h0, d}, q);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    wb_cycle(a, 1'b0, 32'h0, rd);
    check(rd, exp);
  endtask

  // Counts ticks of each clock output over a window of w cycles.
  task automatic count_win(input int w, output int df, output int dsub, output int dsys,
                           output int dsl);
    int f0, s0, y0, l0;
    f0 = n_fast;
    s0 = n_sub;
    y0 = n_sys;
    l0 = n_slow;
    repeat (w) @(posedge sys_clk);
    df = n_fast - f0;
    dsub = n_sub - s0;
    dsys = n_sys - y0;
    dsl = n_slow - l0;
  endtask

  task automatic pulse(input logic is_halt);
    @(posedge sys_clk);
    if (is_halt) halt <= 1'b1;
    else wake <= 1'b1;
    @(posedge sys_clk);
    halt <= 1'b0;
    wake <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  // Reset values, the unmapped hole and the first settling of the fast oscillator.
  task automatic t_reset();
    check(32'(cpu_run), 32'h1);
    check(32'(op_mode), 32'(SCM_FAST));
    rd_chk(`SCM_ADR_SCC, 32'h00);
    rd_chk(`SCM_ADR_FOC, 32'h01);
    rd_chk(4'hC, 32'h00);
    wr(4'hC, 8'hFF);
    rd_chk(`SCM_ADR_SCC, 32'h00);
    repeat (420) @(posedge sys_clk);
    rd_chk(`SCM_ADR_FOC, 32'h03);
    wr(`SCM_ADR_FOC, 8'h01);
    rd_chk(`SCM_ADR_FOC, 32'h01);
    repeat (420) @(posedge sys_clk);
    rd_chk(`SCM_ADR_FOC, 32'h03);
    wr(`SCM_ADR_SCC, 8'h1F);
    rd_chk(`SCM_ADR_SCC, 32'h03);
    $display("test reset done");
  endtask

  // Every fast division, measured against the fast clock ticks.
  task automatic t_div();
    int df, dsub, dsys, dsl, err;
    for (int s = 0; s < 7; s++) begin
      wr(`SCM_ADR_SCC, 8'(s << 5));
      repeat (300) @(posedge sys_clk);
      check(32'(op_mode), 32'(SCM_FAST));
      check(32'(fast_osc_run), 32'h1);
      count_win(2100, df, dsub, dsys, dsl);
      err = df - (dsys << s);
      check(32'(err < (2 << s) && err > -(2 << s) && dsys > 2), 32'h1);
      check(32'(dsub > 1 && dsl > 1), 32'h1);
    end
    $display("test divide done");
  endtask

  // Sub clock as system clock, with the fast enable switched off and on.
  task automatic t_slow();
    int df, dsub, dsys, dsl;
    wr(`SCM_ADR_SCC, 8'hE0);
    repeat (400) @(posedge sys_clk);
    check(32'(op_mode), 32'(SCM_SLOW));
    rd_chk(`SCM_ADR_STAT, 32'(SCM_SLOW));
    count_win(2400, df, dsub, dsys, dsl);
    check(32'(dsys), 32'(dsub));
    check(32'(dsub > 1), 32'h1);
    wr(`SCM_ADR_FOC, 8'h00);
    repeat (5) @(posedge sys_clk);
    check(32'(fast_osc_run), 32'h0);
    count_win(100, df, dsub, dsys, dsl);
    check(32'(df), 32'h0);
    wr(`SCM_ADR_FOC, 8'h01);
    repeat (5) @(posedge sys_clk);
    check(32'(fast_osc_run), 32'h1);
    $display("test slow done");
  endtask

  // Every keep-bit pair under both select kinds; the watchdog follows the select kind.
  task automatic t_halt();
    int df, dsub, dsys, dsl;
    logic s7, kf, ks, sys_on;
    scm_mode_t m;
    for (int c = 0; c < 8; c++) begin
      s7 = c[2];
      kf = c[1];
      ks = c[0];
      wdt_enable <= s7;
      wr(`SCM_ADR_SCC, {s7, s7, s7, 3'h0, kf, ks});
      repeat (1300) @(posedge sys_clk);
      pulse(1'b1);
      m = kf ? (ks ? SCM_IDLE1 : SCM_IDLE2) : (ks ? SCM_IDLE0 : SCM_SLEEP);
      sys_on = (kf & ks) | (ks & ~kf & s7) | (kf & ~ks & ~s7);
      check(32'(cpu_run), 32'h0);
      check(32'(op_mode), 32'(m));
      check(32'(fast_osc_run), 32'(kf));
      check(32'(slow_osc_run), 32'(kf | ks | s7));
      count_win(1800, df, dsub, dsys, dsl);
      check(32'(dsys > 0), 32'(sys_on));
      check(32'(df > 0), 32'(kf));
      check(32'(dsub > 0), 32'(ks));
      check(32'(dsl > 0), 32'(kf | ks | s7));
      pulse(1'b0);
      check(32'(cpu_run), 32'h1);
    end
    $display("test halt done");
  endtask

  // Reset is held for three cycles, then the scenarios run in order.
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_div();
    t_slow();
    t_halt();
    final_report();
  end
endmodule
